// File: include/ts_records_regs.vh
// Constants for the time-stamped message record store
`ifndef TS_RECORDS_REGS_VH
`define TS_RECORDS_REGS_VH

// Record numbering and read answers
`define REC_FIRST        8'h64
`define REC_LAST         8'h72
`define REC_NUM          15
`define REC_IDX_LAST     4'hE
`define CFG_RECORD       8'hF0
`define ERR_NO_RECORD    16'h80B0
`define HDR_READ_CODE    8'h5E
`define HDR_SLOT         8'h00
`define HDR_BYTES        3'h4

// Message geometry
`define MSG_PER_REC      5'h14
`define MSG_LAST_SLOT    5'h13
`define MSG_BYTES        4'hC
`define MSG_LAST_BYTE    4'hB
`define STORE_DEPTH      300
`define MSG_W            96

// Message fields
`define SLOT_MIN         8'h04
`define SLOT_MAX         8'h0B
`define SLOT_SELF        8'h02
`define CHAN_MAX         8'h0F
`define STATUS_IN        8'h80
`define STATUS_OUT       8'h00
`define RESERVED_BYTE    8'h00

// Special message codes and properties
`define CODE_STARTUP     8'h01
`define CODE_SYNC_FAIL   8'h02
`define CODE_UNUSED      8'h03
`define CODE_SYNC_DIFF   8'h04
`define CODE_STOP        8'h05
`define CODE_OVERFLOW    8'h06
`define CODE_CHANGEOVER  8'h07
`define CODE_RED_LOSS    8'h08
`define PROP_BEGIN       8'h01
`define PROP_END         8'h00

// Time synchronisation tolerance, in ms and in 2^-32 s units
`define SYNC_TOL_MS      10
`define SYNC_TOL_FRAC    (((64'd`SYNC_TOL_MS) << 32) / 64'd1000)

`endif

// File: verilog/message_assembler.v
// Builds 12-byte signal and special messages from incoming events
`timescale 1ns/1ns
`include "ts_records_regs.vh"

module message_assembler (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_arst_n,
  // Time base
  input  wire [63:0]       i_time_now,
  // Synchronisation events
  input  wire              i_sync_diff,
  input  wire [63:0]       i_sync_time,
  input  wire              i_sync_fail,
  // Special events
  input  wire              i_spec_valid,
  input  wire [7:0]        i_spec_code,
  input  wire              i_spec_prop,
  // Signal change events
  input  wire              i_sig_valid,
  input  wire [7:0]        i_sig_slot,
  input  wire [7:0]        i_sig_channel,
  input  wire              i_sig_incoming,
  output wire              o_ev_ready,
  // Message output
  output wire              o_msg_valid,
  output wire [95:0]       o_msg,
  input  wire              i_msg_ready
);

  reg              out_valid_reg;
  reg [95:0]       out_msg_reg;
  reg              pair_pend_reg;
  reg [95:0]       pair_msg_reg;
  wire             take;
  wire             spec_ok;
  wire             sig_ok;

  // Byte 3 always zero, last 8 bytes seconds then fraction
  function [95:0] build;
    input [7:0]  b0;
    input [7:0]  b1;
    input [7:0]  b2;
    input [63:0] stamp;
    begin
      build = {b0, b1, b2, `RESERVED_BYTE, stamp};
    end
  endfunction

  assign take = ~out_valid_reg | i_msg_ready;
  assign o_ev_ready = take & ~pair_pend_reg;
  assign o_msg_valid = out_valid_reg;
  assign o_msg = out_msg_reg;

  // Only externally sourced codes pass; code 03 is never emitted
  assign spec_ok = i_spec_valid &
                   ((i_spec_code == `CODE_STARTUP) |
                    (i_spec_code == `CODE_STOP) |
                    (i_spec_code == `CODE_CHANGEOVER) |
                    (i_spec_code == `CODE_RED_LOSS));
  assign sig_ok = i_sig_valid &
                  (i_sig_slot >= `SLOT_MIN) &
                  (i_sig_slot <= `SLOT_MAX) &
                  (i_sig_channel <= `CHAN_MAX);

  // ===========================================================
  // Event priority: pair tail, sync, special, signal
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_valid_reg <= 1'b0;
      out_msg_reg   <= 96'h0;
      pair_pend_reg <= 1'b0;
      pair_msg_reg  <= 96'h0;
    end else if (take) begin
      out_valid_reg <= 1'b1;
      if (pair_pend_reg) begin
        out_msg_reg   <= pair_msg_reg;
        pair_pend_reg <= 1'b0;
      end else if (i_sync_diff) begin
        out_msg_reg   <= build(`SLOT_SELF, `CODE_SYNC_DIFF,
                               `PROP_BEGIN, i_time_now);
        pair_msg_reg  <= build(`SLOT_SELF, `CODE_SYNC_DIFF,
                               `PROP_END, i_sync_time);
        pair_pend_reg <= 1'b1;
      end else if (i_sync_fail) begin
        out_msg_reg <= build(`SLOT_SELF, `CODE_SYNC_FAIL,
                             `PROP_BEGIN, i_time_now);
      end else if (spec_ok) begin
        out_msg_reg <= build(`SLOT_SELF, i_spec_code,
                             i_spec_prop ? `PROP_BEGIN : `PROP_END,
                             i_time_now);
      end else if (sig_ok) begin
        out_msg_reg <= build(i_sig_slot, i_sig_channel,
                             i_sig_incoming ? `STATUS_IN : `STATUS_OUT,
                             i_time_now);
      end else begin
        out_valid_reg <= 1'b0;
      end
    end
  end

endmodule // message_assembler

// File: verilog/timestamp_message_records.v
// Time-stamped message record store with record read-out
//
// Summary of operation
// - Record outside 100 to 114 answers 80B0h
// - Unconfigured device answers every read with 80B0h
// - Exactly fifteen message records, numbered 100-114
// - Up to twenty messages per record, twelve bytes
// - Frame header: 5Eh, slot 00h, record, count
// - Signal messages only from slots 4 to 11
// - Slot, channel, status bit7 incoming, reserved
// - Channel byte limited to 0 to 15
// - Last eight bytes hold signal change time
// - Special message slot is always 2
// - Codes 01h, 05h used; 03h never
// - Sync frame failure emits code 02h
// - Time difference over 10 ms emits 04h pair
// - Pair property 01h carries internal clock time
// - Pair property 00h carries new sync time
// - Overflow emits 06h incoming, then discards messages
// - Redundancy changeover emits 07h begin and end
// - Redundancy information loss emits 08h in/out
// - Special message ends with event time stamp
// - Stamp: seconds bytes 0-3, fraction bytes 4-7
// - All records full: last entry is overflow
// - Notification gives record 64h-72h and count
`timescale 1ns/1ns
`include "ts_records_regs.vh"

module timestamp_message_records (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_arst_n,
  // Configuration record written
  input  wire              i_cfg_written,
  // Internal clock, seconds in [63:32], fraction in [31:0]
  input  wire [63:0]       i_time_now,
  // Received synchronisation time
  input  wire              i_sync_valid,
  input  wire [63:0]       i_sync_time,
  input  wire              i_sync_fail,
  // Special events from this module
  input  wire              i_spec_valid,
  input  wire [7:0]        i_spec_code,
  input  wire              i_spec_prop,
  // Signal changes from input modules
  input  wire              i_sig_valid,
  input  wire [7:0]        i_sig_slot,
  input  wire [7:0]        i_sig_channel,
  input  wire              i_sig_incoming,
  output wire              o_ev_ready,
  // Record read service
  input  wire              i_rd_req,
  input  wire [7:0]        i_rd_record,
  output wire              o_rd_busy,
  output reg               o_rd_valid,
  output reg  [7:0]        o_rd_data,
  output reg               o_rd_last,
  output reg               o_rd_err,
  output reg  [15:0]       o_rd_err_code,
  // Record ready notification
  output reg               o_irq_valid,
  output reg  [7:0]        o_irq_record,
  output reg  [7:0]        o_irq_count,
  // Status
  output wire              o_overflow
);

  // ===========================================================
  // Declarations
  localparam RD_IDLE = 2'b00;
  localparam RD_HDR  = 2'b01;
  localparam RD_BODY = 2'b10;

  reg  [95:0]      store_mem [0:`STORE_DEPTH-1];
  reg  [4:0]       cnt_reg [0:`REC_NUM-1];
  reg  [3:0]       wr_rec_reg;
  reg              ovf_reg;
  reg  [1:0]       rd_state_reg;
  reg  [3:0]       rd_rec_reg;
  reg  [4:0]       rd_cnt_reg;
  reg  [4:0]       rd_msg_reg;
  reg  [3:0]       rd_byte_reg;

  wire             msg_valid;
  wire [95:0]      msg;
  wire             msg_ready;
  wire             store;
  wire             rd_done;
  wire             rd_start;
  wire             rd_ok;
  wire [14:0]      rec_empty;
  wire [14:0]      other_empty;
  wire [4:0]       next_free;
  wire [4:0]       wr_cnt;
  wire [63:0]      sync_delta;
  wire             sync_far;
  wire [95:0]      rd_word;
  wire [7:0]       rd_idx = i_rd_record - `REC_FIRST;

  reg              mem_we;
  reg  [8:0]       mem_addr;
  reg  [95:0]      mem_wdata;

  // ===========================================================
  // Functions
  function in_range;
    input [7:0] rec;
    begin
      in_range = (rec >= `REC_FIRST) && (rec <= `REC_LAST);
    end
  endfunction
  // Record index times twenty plus slot
  function [8:0] msg_addr;
    input [3:0] rec;
    input [4:0] slot;
    begin
      msg_addr = {1'b0, rec, 4'h0} + {3'h0, rec, 2'h0} + {4'h0, slot};
    end
  endfunction

  // Bytes counted after the header
  function [7:0] body_bytes;
    input [4:0] cnt;
    begin
      body_bytes = {cnt, 3'h0} + {1'b0, cnt, 2'h0};
    end
  endfunction

  // Lowest empty record, bit 4 set when none
  function [4:0] first_free;
    input [14:0] vec;
    integer k;
    begin
      first_free = 5'h10;
      for (k = `REC_NUM - 1; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          first_free = {1'b0, k[3:0]};
        end
      end
    end
  endfunction

  // Byte 0 is the most significant byte of the message word
  function [7:0] pick_byte;
    input [95:0] word;
    input [3:0]  idx;
    begin
      case (idx)
        4'h0:    pick_byte = word[95:88];
        4'h1:    pick_byte = word[87:80];
        4'h2:    pick_byte = word[79:72];
        4'h3:    pick_byte = word[71:64];
        4'h4:    pick_byte = word[63:56];
        4'h5:    pick_byte = word[55:48];
        4'h6:    pick_byte = word[47:40];
        4'h7:    pick_byte = word[39:32];
        4'h8:    pick_byte = word[31:24];
        4'h9:    pick_byte = word[23:16];
        4'hA:    pick_byte = word[15:8];
        4'hB:    pick_byte = word[7:0];
        default: pick_byte = 8'h00;
      endcase
    end
  endfunction

  // ===========================================================
  // Synchronisation time comparison
  assign sync_delta = (i_sync_time >= i_time_now) ?
                      (i_sync_time - i_time_now) :
                      (i_time_now - i_sync_time);
  assign sync_far = i_sync_valid & (sync_delta > `SYNC_TOL_FRAC);

  // ===========================================================
  // Message assembly
  message_assembler u_assembler (
    .i_clk          (i_clk),
    .i_arst_n       (i_arst_n),
    .i_time_now     (i_time_now),
    .i_sync_diff    (sync_far),
    .i_sync_time    (i_sync_time),
    .i_sync_fail    (i_sync_fail),
    .i_spec_valid   (i_spec_valid),
    .i_spec_code    (i_spec_code),
    .i_spec_prop    (i_spec_prop),
    .i_sig_valid    (i_sig_valid),
    .i_sig_slot     (i_sig_slot),
    .i_sig_channel  (i_sig_channel),
    .i_sig_incoming (i_sig_incoming),
    .o_ev_ready     (o_ev_ready),
    .o_msg_valid    (msg_valid),
    .o_msg          (msg),
    .i_msg_ready    (msg_ready)
  );

  // ===========================================================
  // Record occupancy
  genvar g;
  generate
    for (g = 0; g < `REC_NUM; g = g + 1) begin : g_empty
      assign rec_empty[g]   = (cnt_reg[g] == 5'h00);
      assign other_empty[g] = rec_empty[g] & (wr_rec_reg != g);
    end
  endgenerate

  assign next_free  = first_free(other_empty);
  assign wr_cnt     = cnt_reg[wr_rec_reg];
  assign o_overflow = ovf_reg;

  // Stall while the filling record is read out or a record is freed
  assign rd_done   = (rd_state_reg == RD_BODY) &&
                     (rd_msg_reg == rd_cnt_reg - 5'h01) &&
                     (rd_byte_reg == `MSG_LAST_BYTE) ||
                     (rd_state_reg == RD_HDR) &&
                     (rd_byte_reg == {1'b0, `HDR_BYTES - 3'h1}) &&
                     (rd_cnt_reg == 5'h00);
  assign msg_ready = ~rd_done & ~rd_start &
                     ~((rd_state_reg != RD_IDLE) &&
                       (rd_rec_reg == wr_rec_reg));
  assign store     = msg_valid & msg_ready & i_cfg_written;

  // ===========================================================
  // Message store write port
  always @* begin
    mem_we    = 1'b0;
    mem_addr  = msg_addr(wr_rec_reg, wr_cnt);
    mem_wdata = msg;
    if (rd_done && ovf_reg) begin
      mem_we    = 1'b1;
      mem_addr  = msg_addr(rd_rec_reg, 5'h00);
      mem_wdata = {`SLOT_SELF, `CODE_OVERFLOW, `PROP_END,
                   `RESERVED_BYTE, i_time_now};
    end else if (store && !ovf_reg) begin
      mem_we = 1'b1;
      if (wr_cnt == `MSG_LAST_SLOT && next_free[4]) begin
        mem_wdata = {`SLOT_SELF, `CODE_OVERFLOW, `PROP_BEGIN,
                     `RESERVED_BYTE, i_time_now};
      end
    end
  end

  always @(posedge i_clk) begin
    if (mem_we) begin
      store_mem[mem_addr] <= mem_wdata;
    end
  end

  // ===========================================================
  // Fill pointer, counts and overflow
  integer r;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (r = 0; r < `REC_NUM; r = r + 1) begin
        cnt_reg[r] <= 5'h00;
      end
      wr_rec_reg   <= 4'h0;
      ovf_reg      <= 1'b0;
      o_irq_valid  <= 1'b0;
      o_irq_record <= 8'h00;
      o_irq_count  <= 8'h00;
    end else begin
      o_irq_valid <= 1'b0;
      if (rd_done) begin
        if (ovf_reg) begin
          cnt_reg[rd_rec_reg] <= 5'h01;
          wr_rec_reg          <= rd_rec_reg;
          ovf_reg             <= 1'b0;
        end else begin
          cnt_reg[rd_rec_reg] <= 5'h00;
        end
      end else if (store && !ovf_reg) begin
        cnt_reg[wr_rec_reg] <= wr_cnt + 5'h01;
        if (wr_cnt == `MSG_LAST_SLOT) begin
          o_irq_valid  <= 1'b1;
          o_irq_record <= `REC_FIRST + {4'h0, wr_rec_reg};
          o_irq_count  <= {3'h0, `MSG_PER_REC};
          if (next_free[4]) begin
            ovf_reg <= 1'b1;
          end else begin
            wr_rec_reg <= next_free[3:0];
          end
        end
      end
    end
  end

  // ===========================================================
  // Record read service
  assign rd_ok     = i_cfg_written & in_range(i_rd_record);
  assign rd_start  = i_rd_req & (rd_state_reg == RD_IDLE);
  assign o_rd_busy = (rd_state_reg != RD_IDLE);
  assign rd_word   = store_mem[msg_addr(rd_rec_reg, rd_msg_reg)];

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_state_reg  <= RD_IDLE;
      rd_rec_reg    <= 4'h0;
      rd_cnt_reg    <= 5'h00;
      rd_msg_reg    <= 5'h00;
      rd_byte_reg   <= 4'h0;
      o_rd_valid    <= 1'b0;
      o_rd_data     <= 8'h00;
      o_rd_last     <= 1'b0;
      o_rd_err      <= 1'b0;
      o_rd_err_code <= 16'h0000;
    end else begin
      o_rd_valid <= 1'b0;
      o_rd_last  <= 1'b0;
      o_rd_err   <= 1'b0;
      case (rd_state_reg)
        RD_IDLE: begin
          if (rd_start && !rd_ok) begin
            o_rd_err      <= 1'b1;
            o_rd_err_code <= `ERR_NO_RECORD;
          end else if (rd_start) begin
            rd_rec_reg   <= rd_idx[3:0];
            rd_cnt_reg   <= cnt_reg[rd_idx[3:0]];
            rd_msg_reg   <= 5'h00;
            rd_byte_reg  <= 4'h0;
            rd_state_reg <= RD_HDR;
          end
        end
        RD_HDR: begin
          o_rd_valid  <= 1'b1;
          rd_byte_reg <= rd_byte_reg + 4'h1;
          case (rd_byte_reg[1:0])
            2'h0:    o_rd_data <= `HDR_READ_CODE;
            2'h1:    o_rd_data <= `HDR_SLOT;
            2'h2:    o_rd_data <= `REC_FIRST + {4'h0, rd_rec_reg};
            default: o_rd_data <= body_bytes(rd_cnt_reg);
          endcase
          if (rd_byte_reg == {1'b0, `HDR_BYTES - 3'h1}) begin
            rd_byte_reg <= 4'h0;
            if (rd_cnt_reg == 5'h00) begin
              o_rd_last    <= 1'b1;
              rd_state_reg <= RD_IDLE;
            end else begin
              rd_state_reg <= RD_BODY;
            end
          end
        end
        RD_BODY: begin
          o_rd_valid  <= 1'b1;
          o_rd_data   <= pick_byte(rd_word, rd_byte_reg);
          rd_byte_reg <= rd_byte_reg + 4'h1;
          if (rd_byte_reg == `MSG_LAST_BYTE) begin
            rd_byte_reg <= 4'h0;
            rd_msg_reg  <= rd_msg_reg + 5'h01;
            if (rd_done) begin
              o_rd_last    <= 1'b1;
              rd_state_reg <= RD_IDLE;
            end
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

endmodule // timestamp_message_records

// File: bench/ts_records_asserts.sv
// Port checks for the message record store
`timescale 1ns/1ns
module ts_records_checker (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // Watched ports
  input wire logic        i_cfg_written,
  input wire logic        i_rd_req,
  input wire logic [7:0]  i_rd_record,
  input wire logic        o_rd_busy,
  input wire logic        o_rd_valid,
  input wire logic [7:0]  o_rd_data,
  input wire logic        o_rd_last,
  input wire logic        o_rd_err,
  input wire logic [15:0] o_rd_err_code,
  input wire logic        o_irq_valid,
  input wire logic [7:0]  o_irq_record,
  input wire logic [7:0]  o_irq_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================
  // Frame tracking
  logic [7:0] rec_reg;
  logic [7:0] len_reg;
  logic [8:0] cnt_reg;
  wire        take = i_rd_req && !o_rd_busy;
  wire        bad  = (i_rd_record < 8'h64) || (i_rd_record > 8'h72);
  wire [8:0]  len  = (cnt_reg == 9'h003) ? {1'b0, o_rd_data} : {1'b0, len_reg};
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_reg <= 8'h00;
      len_reg <= 8'h00;
      cnt_reg <= 9'h000;
    end else begin
      if (take) rec_reg <= i_rd_record;
      if (o_rd_valid) cnt_reg <= o_rd_last ? 9'h000 : cnt_reg + 9'h001;
      if (o_rd_valid && cnt_reg == 9'h003) len_reg <= o_rd_data;
    end
  end
  // ==========================================
  // Assertions
  a_err_code_value: assert property (o_rd_err |->
    o_rd_err_code == 16'h80B0) else $error("read error without code 80B0");
  a_bad_record_err: assert property (take && bad |=>
    o_rd_err && !o_rd_valid) else $error("out of range record not refused");
  a_no_config_err: assert property (take && !i_cfg_written |=>
    o_rd_err) else $error("read before configuration not refused");
  a_good_record_data: assert property (take && i_cfg_written
    && !bad |=> !o_rd_err ##[0:2] o_rd_valid) else $error("no data streamed");
  a_header_bytes: assert property ($rose(o_rd_valid) |->
    o_rd_data == 8'h5E ##1 (o_rd_valid && o_rd_data == 8'h00) ##1
    (o_rd_valid && o_rd_data == rec_reg)) else $error("frame header wrong");
  a_frame_length: assert property (o_rd_last |-> o_rd_valid &&
    cnt_reg == len + 9'h003) else $error("length differs from header");
  a_count_multiple: assert property (o_rd_valid && cnt_reg == 9'h003
    |-> o_rd_data <= 8'hF0 && o_rd_data % 8'h0C == 8'h00)
    else $error("bad byte count");
  a_irq_fields: assert property (o_irq_valid |->
    o_irq_record >= 8'h64 && o_irq_record <= 8'h72 && o_irq_count == 8'h14)
    else $error("bad notification");
endmodule // ts_records_checker

bind timestamp_message_records ts_records_checker ts_records_checker_i (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg_written(i_cfg_written),
  .i_rd_req(i_rd_req), .i_rd_record(i_rd_record), .o_rd_busy(o_rd_busy),
  .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_last(o_rd_last),
  .o_rd_err(o_rd_err), .o_rd_err_code(o_rd_err_code),
  .o_irq_valid(o_irq_valid), .o_irq_record(o_irq_record),
  .o_irq_count(o_irq_count));

// File: bench/dp_master_model.sv
// Bus master model that fetches message records through the read service
`timescale 1ns/1ns
module dp_master_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Commands from the bench
  input  wire logic        i_start,
  input  wire logic [7:0]  i_record,
  output logic             o_done,
  output logic             o_got_err,
  output logic [15:0]      o_err_code,
  output logic [7:0]       o_buf [0:243],
  output int               o_len,
  // Read service of the device
  output logic             o_rd_req,
  output logic [7:0]       o_rd_record,
  input  wire logic        i_rd_busy,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic        i_rd_last,
  input  wire logic        i_rd_err,
  input  wire logic [15:0] i_rd_err_code
);
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_req <= 1'b0;
      o_rd_record <= 8'h00;
      o_done <= 1'b0;
      o_got_err <= 1'b0;
      o_err_code <= 16'h0000;
      o_len <= 0;
    end else begin
      if (i_start) begin
        o_rd_req <= 1'b1;
        o_rd_record <= i_record;
        o_done <= 1'b0;
        o_got_err <= 1'b0;
        o_len <= 0;
      end else if (o_rd_req && !i_rd_busy) begin
        // Released number lines no longer show the requested record
        o_rd_req <= 1'b0;
        o_rd_record <= ~o_rd_record;
      end
      if (i_rd_valid && o_len < 244) begin
        o_buf[o_len] <= i_rd_data;
        o_len <= o_len + 1;
        o_done <= i_rd_last;
      end
      if (i_rd_err) begin
        o_done <= 1'b1;
        o_got_err <= 1'b1;
        o_err_code <= i_rd_err_code;
      end
    end
  end
endmodule // dp_master_model

// File: bench/tb.sv
// Self-checking bench for the time-stamped message record store
`timescale 1ns/1ns
module tb;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_cfg_written = 1'b0;
  logic [63:0] i_time_now = 64'h0, i_sync_time = 64'h0;
  logic        i_sync_valid = 1'b0, i_sync_fail = 1'b0, i_spec_valid = 1'b0;
  logic [7:0]  i_spec_code = 8'h00, i_sig_slot = 8'h00, i_sig_channel = 8'h00;
  logic        i_spec_prop = 1'b0, i_sig_valid = 1'b0, i_sig_incoming = 1'b0;
  logic        o_ev_ready, i_rd_req, o_rd_busy, o_rd_valid, o_rd_last, o_rd_err;
  logic [7:0]  i_rd_record, o_rd_data, o_irq_record, o_irq_count, rd_rec;
  logic [15:0] o_rd_err_code, rd_code;
  logic        o_irq_valid, o_overflow, rd_start = 1'b0, rd_done, rd_err;
  logic [7:0]  rbuf [0:243];
  logic [63:0] tnow = 64'h1234_5678_9ABC_DEF0, last_t;
  int          rd_len, num_errors = 0, checked = 0, irqs = 0;
  int          exp_set [logic [95:0]];

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_irq_valid === 1'b1) irqs++;

  timestamp_message_records timestamp_message_records_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg_written(i_cfg_written),
    .i_time_now(i_time_now), .i_sync_valid(i_sync_valid),
    .i_sync_time(i_sync_time), .i_sync_fail(i_sync_fail),
    .i_spec_valid(i_spec_valid), .i_spec_code(i_spec_code),
    .i_spec_prop(i_spec_prop), .i_sig_valid(i_sig_valid),
    .i_sig_slot(i_sig_slot), .i_sig_channel(i_sig_channel),
    .i_sig_incoming(i_sig_incoming), .o_ev_ready(o_ev_ready),
    .i_rd_req(i_rd_req), .i_rd_record(i_rd_record), .o_rd_busy(o_rd_busy),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_last(o_rd_last),
    .o_rd_err(o_rd_err), .o_rd_err_code(o_rd_err_code),
    .o_irq_valid(o_irq_valid), .o_irq_record(o_irq_record),
    .o_irq_count(o_irq_count), .o_overflow(o_overflow));

  dp_master_model dp_master_model_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(rd_start),
    .i_record(rd_rec), .o_done(rd_done), .o_got_err(rd_err),
    .o_err_code(rd_code), .o_buf(rbuf), .o_len(rd_len),
    .o_rd_req(i_rd_req), .o_rd_record(i_rd_record), .i_rd_busy(o_rd_busy),
    .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .i_rd_last(o_rd_last),
    .i_rd_err(o_rd_err), .i_rd_err_code(o_rd_err_code));

  // ==========================================
  // Shared tasks
  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic want(input logic [7:0] s, c, st, input logic [63:0] t);
    exp_set[{s, c, st, 8'h00, t}] = 1;
  endtask
  // Event kinds in k: bit0 signal, bit1 special, bit2 sync, bit3 sync fail
  task automatic fire(input logic [3:0] k, input logic [7:0] a, b,
                      input logic p, input logic [63:0] sy);
    int n;
    @(posedge i_clk);
    {i_sync_fail, i_sync_valid, i_spec_valid, i_sig_valid} <= k;
    i_time_now <= tnow;
    i_sync_time <= sy;
    {i_sig_slot, i_spec_code, i_sig_channel} <= {a, a, b};
    {i_sig_incoming, i_spec_prop} <= {p, p};
    @(negedge i_clk);
    for (n = 0; n < 500 && o_ev_ready !== 1'b1; n++) @(negedge i_clk);
    if (n == 500) begin num_errors++; end_of_test(); end
    @(posedge i_clk);
    {i_sync_fail, i_sync_valid, i_spec_valid, i_sig_valid} <= 4'h0;
    last_t = tnow;
    tnow += 64'h0000_0001_0000_1000;
  endtask
  task automatic read_rec(input logic [7:0] r);
    int n;
    @(posedge i_clk);
    rd_start <= 1'b1;
    rd_rec <= r;
    @(posedge i_clk);
    rd_start <= 1'b0;
    @(negedge i_clk);
    for (n = 0; n < 600 && rd_done !== 1'b1; n++) @(negedge i_clk);
    if (n == 600) begin num_errors++; end_of_test(); end
  endtask
  // Reads every record and removes each message found from the expected set
  task automatic read_all();
    logic [95:0] m;
    int n;
    repeat (4) @(posedge i_clk);
    for (int r = 8'h64; r <= 8'h72; r++) begin
      read_rec(r[7:0]);
      cmp(rd_err, 1'b0);
      cmp({rbuf[0], rbuf[1], rbuf[2]}, {16'h5E00, r[7:0]});
      n = rbuf[3] / 12;
      cmp(rd_len, n * 12 + 4);
      cmp(rbuf[3] % 12 == 0 && n <= 20, 1'b1);
      for (int i = 0; i < n; i++) begin
        for (int j = 0; j < 12; j++) m = {m[87:0], rbuf[4 + 12 * i + j]};
        cmp(exp_set.exists(m), 1'b1);
        exp_set.delete(m);
      end
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic s_unconfigured();
    fire(4'h1, 8'h04, 8'h01, 1'b1, 64'h0);
    read_rec(8'h64);
    cmp({rd_err, rd_code}, {1'b1, 16'h80B0});
  endtask

  task automatic s_bad_records();
    logic [7:0] bad [5] = '{8'h63, 8'h73, 8'h00, 8'hF0, 8'hFF};
    @(posedge i_clk);
    i_cfg_written <= 1'b1;
    foreach (bad[i]) begin
      read_rec(bad[i]);
      cmp({rd_err, rd_code}, {1'b1, 16'h80B0});
    end
  endtask

  task automatic s_signals();
    logic [24:0] tab [6] = '{{8'd4, 8'd0, 1'b1}, {8'd11, 8'd15, 1'b0},
      {8'd3, 8'd1, 1'b1}, {8'd12, 8'd2, 1'b1}, {8'd5, 8'd16, 1'b1},
      {8'd8, 8'd7, 1'b1}};
    foreach (tab[i]) begin
      if (tab[i][24:17] inside {[4:11]} && tab[i][16:9] <= 15)
        want(tab[i][24:17], tab[i][16:9], {tab[i][0], 7'h00}, tnow);
      fire(4'h1, tab[i][24:17], tab[i][16:9], tab[i][0], 64'h0);
    end
    read_all();
    cmp(exp_set.num(), 0);
  endtask

  task automatic s_specials();
    logic [7:0] codes [6] = '{8'h01, 8'h05, 8'h07, 8'h08, 8'h03, 8'h02};
    foreach (codes[i]) for (int p = 1; p >= 0; p--) begin
      if (i < 4) want(8'h02, codes[i], {7'h00, p[0]}, tnow);
      fire(4'h2, codes[i], 8'h00, p[0], 64'h0);
    end
    want(8'h02, 8'h02, 8'h01, tnow);
    fire(4'h8, 8'h00, 8'h00, 1'b0, 64'h0);
    want(8'h02, 8'h04, 8'h01, tnow);
    want(8'h02, 8'h04, 8'h00, tnow + 64'h0300_0000);
    fire(4'h4, 8'h00, 8'h00, 1'b0, tnow + 64'h0300_0000);
    fire(4'h4, 8'h00, 8'h00, 1'b0, tnow + 64'h0200_0000);
    want(8'h02, 8'h04, 8'h01, tnow);
    want(8'h02, 8'h04, 8'h00, tnow - 64'h0300_0000);
    fire(4'h4, 8'h00, 8'h00, 1'b0, tnow - 64'h0300_0000);
    read_all();
    cmp(exp_set.num(), 0);
  endtask

  task automatic s_overflow();
    irqs = 0;
    for (int i = 0; i < 301; i++) begin
      if (i < 299) want(8'h04 + i[7:0] % 8, i[7:0] % 16, 8'h80, tnow);
      else if (i == 299) want(8'h02, 8'h06, 8'h01, tnow);
      fire(4'h1, 8'h04 + i[7:0] % 8, i[7:0] % 16, 1'b1, 64'h0);
    end
    repeat (4) @(posedge i_clk);
    cmp(o_overflow, 1'b1);
    cmp(irqs, 15);
    cmp({o_irq_record, o_irq_count}, 16'h7214);
    want(8'h02, 8'h06, 8'h00, last_t);
    read_all();
    read_all();
    cmp(exp_set.num(), 0);
    cmp(o_overflow, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    s_unconfigured();
    s_bad_records();
    s_signals();
    s_specials();
    s_overflow();
    end_of_test();
  end
endmodule // tb
